//--- hw/ppi_sync.sv
// Two-stage synchroniser for the shared pin input.
`timescale 1ns/1ps
`include "ppi_defines.svh"
module ppi_sync (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic async_in,
    output logic sync_out
);
    logic stage1_r;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stage1_r <= `PPI_PIN_IDLE;
            sync_out <= `PPI_PIN_IDLE;
        end else begin
            stage1_r <= async_in;
            sync_out <= stage1_r;
        end
    end
endmodule

//--- hw/ppi_top.sv
// Shared power-down input and interrupt output pin with its registers.
`timescale 1ns/1ps
`include "ppi_defines.svh"

// Operation
// R01: After reset the pin is a power-down input; interrupt output inactive.
// R02: Interrupt control bit 0 turns the pin into an active-low interrupt.
// R03: Pin held low as input powers down, like basic control bit 11.
// R04: Weak pull-up; external pull-down starts the device powered down.
// R05: Registers stay reachable; output enable ends pin-forced sleep.
// R06: Sources off at reset; need enable bit 1 and their mask bit.
// R07: An enabled interrupt drives the pin low without waiting for a clock.
// R08: High byte of status shows one flag for each pending source.
// R09: Reading the status register clears all flags, releasing the pin.
// R10: Software writes 0003h to control, 0060h to status, then watches pin.
// R11: Pin low exactly while enables set and a masked pending flag exists.
module ppi_top #(
    parameter int SRC_N = `PPI_SRC_N
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire ppi_pkg::ppi_addr_t reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire ppi_pkg::ppi_word_t reg_wdata,
    output ppi_pkg::ppi_word_t reg_rdata,
    output logic reg_rvalid,
    input wire ppi_pkg::ppi_src_t irq_event,
    input wire logic sleep_irq_pin_i,
    output logic sleep_irq_pin_o,
    output logic sleep_irq_pin_oe,
    output logic power_down,
    output ppi_pkg::ppi_pin_mode_t pin_mode
);
    import ppi_pkg::*;

    generate
        if (SRC_N != `PPI_SRC_N) begin : g_bad_src_n
            $error("SRC_N must equal the width of the flag byte.");
        end
    endgenerate

    ppi_word_t basic_ctrl_r;
    logic [1:0] irq_ctrl_r;
    ppi_src_t irq_mask_r;
    ppi_src_t irq_flag_r;
    ppi_word_t rdata_r;
    logic rvalid_r;
    logic pin_sync;

    ppi_sync u_pin_sync (
        .mclk(mclk),
        .arst_n(arst_n),
        .async_in(sleep_irq_pin_i),
        .sync_out(pin_sync)
    );

    wire sel_basic = reg_addr == `PPI_BASIC_CTRL_OFS;
    wire sel_ctrl = reg_addr == `PPI_IRQ_CTRL_OFS;
    wire sel_stat = reg_addr == `PPI_IRQ_STAT_OFS;
    wire wr_basic = reg_wr && sel_basic;
    wire wr_ctrl = reg_wr && sel_ctrl;
    wire wr_stat = reg_wr && sel_stat;
    wire rd_stat = reg_rd && sel_stat;

    wire pin_oe_bit = irq_ctrl_r[`PPI_OE_BIT];
    wire irq_en_bit = irq_ctrl_r[`PPI_EN_BIT];

    // The pin is an input until the output enable bit is set. [R01] [R02]
    assign pin_mode = pin_oe_bit ? PPI_PIN_IRQ_OUT : PPI_PIN_SLEEP_IN;

    // A low pin forces sleep only while it is an input. [R03] [R04] [R05]
    wire pin_sleep = (pin_mode == PPI_PIN_SLEEP_IN) && !pin_sync;
    assign power_down = basic_ctrl_r[`PPI_PD_BIT] || pin_sleep;

    // New events join the flags combinationally so the pin falls at once.
    wire [SRC_N-1:0] pending = irq_flag_r | irq_event;
    wire irq_hit = |(pending & irq_mask_r);
    assign sleep_irq_pin_oe = pin_oe_bit && irq_en_bit
        && irq_hit; // [R06] [R07] [R11]
    assign sleep_irq_pin_o = 1'b0;

    wire [SRC_N-1:0] flag_nxt;
    genvar gi;
    generate
        for (gi = 0; gi < SRC_N; gi++) begin : g_flag
            // A set in the clearing cycle wins over the clear. [R08] [R09]
            assign flag_nxt[gi] = irq_event[gi] || (irq_flag_r[gi] && !rd_stat);
        end
    endgenerate

    ppi_word_t basic_rd;
    assign basic_rd = {basic_ctrl_r[15:12], power_down, basic_ctrl_r[10:0]};

    ppi_word_t rdata_nxt;
    assign rdata_nxt = sel_basic ? basic_rd :
                       sel_ctrl ? {14'h0000, irq_ctrl_r} :
                       sel_stat ? {irq_flag_r, irq_mask_r} : 16'h0000; // [R08]

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            basic_ctrl_r <= `PPI_BASIC_CTRL_RST;
            irq_ctrl_r <= `PPI_IRQ_CTRL_RST; // [R01] [R06]
            irq_mask_r <= `PPI_MASK_RST; // [R06]
        end else begin
            if (wr_basic) begin
                basic_ctrl_r <= reg_wdata;
            end
            if (wr_ctrl) begin
                irq_ctrl_r <= reg_wdata[1:0]; // [R02]
            end
            if (wr_stat) begin
                irq_mask_r <= reg_wdata[`PPI_MASK_LSB +: `PPI_SRC_N]; // [R06]
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irq_flag_r <= `PPI_FLAG_RST;
            rdata_r <= 16'h0000;
            rvalid_r <= 1'b0;
        end else begin
            irq_flag_r <= flag_nxt; // [R08] [R09]
            rvalid_r <= reg_rd;
            if (reg_rd) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence s_pin_low_input;
        (!sleep_irq_pin_i && pin_mode == PPI_PIN_SLEEP_IN) [*3];
    endsequence

    sequence s_stat_read;
        rd_stat && irq_event == 8'h00;
    endsequence

    a_reset_input_mode: assert property ( // [R01]
        irq_ctrl_r == 2'h0
            |-> pin_mode == PPI_PIN_SLEEP_IN && !sleep_irq_pin_oe
    ) else $error("Pin is not a plain input with control cleared.");

    a_oe_write_mode: assert property ( // [R02]
        wr_ctrl && reg_wdata[0] |=> pin_mode == PPI_PIN_IRQ_OUT
    ) else $error("Output enable write did not switch the pin.");

    a_pin_low_sleep: assert property ( // [R03] [R04]
        s_pin_low_input |-> power_down
    ) else $error("Held-low input pin did not power the device down.");

    a_oe_leaves_sleep: assert property ( // [R05]
        pin_mode == PPI_PIN_IRQ_OUT && !basic_ctrl_r[11] |-> !power_down
    ) else $error("Device stayed asleep with the pin as output.");

    a_enable_gates_pin: assert property ( // [R06]
        (!irq_en_bit || irq_mask_r == 8'h00) |-> !sleep_irq_pin_oe
    ) else $error("Pin driven without global enable or mask.");

    a_async_assert: assert property ( // [R07]
        pin_oe_bit && irq_en_bit && |(irq_event & irq_mask_r)
            |-> sleep_irq_pin_oe
    ) else $error("Enabled event did not drive the pin in its cycle.");

    a_flag_capture: assert property ( // [R08]
        irq_event != 8'h00
            |=> (irq_flag_r & $past(irq_event)) == $past(irq_event)
    ) else $error("Event did not leave its pending flag.");

    a_read_clears: assert property ( // [R09]
        s_stat_read |=> irq_flag_r == 8'h00 && reg_rvalid
            && reg_rdata[15:8] == $past(irq_flag_r)
    ) else $error("Status read did not return and clear the flags.");

    a_pin_exact: assert property ( // [R11]
        pin_oe_bit && irq_en_bit && |(irq_flag_r & irq_mask_r)
            |-> sleep_irq_pin_oe
    ) else $error("Masked pending flag did not hold the pin low.");

    a_read_release: assert property ( // [R09] [R11]
        s_stat_read ##1 irq_event == 8'h00 |-> !sleep_irq_pin_oe
    ) else $error("Pin still low after flags were read away.");
endmodule

//--- inc/ppi_defines.svh
// Register offsets, field positions and reset values of the pin controller.
`ifndef PPI_DEFINES_SVH
`define PPI_DEFINES_SVH

`define PPI_ADDR_W 5
`define PPI_DATA_W 16
`define PPI_SRC_N 8

`define PPI_BASIC_CTRL_OFS 5'h00
`define PPI_IRQ_CTRL_OFS 5'h11
`define PPI_IRQ_STAT_OFS 5'h12

`define PPI_PD_BIT 11
`define PPI_OE_BIT 0
`define PPI_EN_BIT 1
`define PPI_MASK_LSB 0
`define PPI_FLAG_LSB 8

`define PPI_BASIC_CTRL_RST 16'h0000
`define PPI_IRQ_CTRL_RST 2'h0
`define PPI_MASK_RST 8'h00
`define PPI_FLAG_RST 8'h00
`define PPI_PIN_IDLE 1'h1

`endif

//--- inc/ppi_pkg.sv
// Types shared by the pin controller files.
`include "ppi_defines.svh"

package ppi_pkg;
    typedef logic [`PPI_ADDR_W-1:0] ppi_addr_t;
    typedef logic [`PPI_DATA_W-1:0] ppi_word_t;
    typedef logic [`PPI_SRC_N-1:0] ppi_src_t;
    typedef enum logic {PPI_PIN_SLEEP_IN, PPI_PIN_IRQ_OUT} ppi_pin_mode_t;
endpackage

//--- test/ppi_pin_model.sv
// Wire model of the shared pin with its pull-up and an external pull-down.
`timescale 1ns/1ps
module ppi_pin_model (
    input wire logic drv_o,
    input wire logic drv_oe,
    input wire logic ext_low,
    output logic pin
);
    // Device drive wins, then the external pull-down, else the pull-up.
    assign pin = drv_oe ? drv_o : !ext_low;
endmodule

//--- test/testbench.sv
// Self-checking bench for the shared sleep and interrupt pin block.
`timescale 1ns/1ps
module testbench;
    import ppi_pkg::*;
    logic mclk = 1'h0, arst_n = 1'h0, ext_low = 1'h0;
    logic reg_wr = 1'h0, reg_rd = 1'h0, p;
    ppi_addr_t reg_addr = 5'h00;
    ppi_word_t reg_wdata = 16'h0000, reg_rdata, q;
    ppi_src_t irq_event = 8'h00;
    logic reg_rvalid, pin, pin_o, pin_oe, power_down;
    ppi_pin_mode_t pin_mode;
    int errors = 0, n_tests = 0;
    always #25 mclk = ~mclk;
    ppi_top ppi_top_i (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .irq_event(irq_event), .sleep_irq_pin_i(pin),
        .sleep_irq_pin_o(pin_o), .sleep_irq_pin_oe(pin_oe),
        .power_down(power_down), .pin_mode(pin_mode));
    ppi_pin_model ppi_pin_model_i (.drv_o(pin_o), .drv_oe(pin_oe),
        .ext_low(ext_low), .pin(pin));
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input ppi_word_t e, ppi_word_t g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input ppi_addr_t a, input ppi_word_t d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'h1;
        @(negedge mclk);
        reg_wr = 1'h0;
    endtask
    task automatic rd(input ppi_addr_t a, output ppi_word_t d);
        int k;
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'h1;
        @(negedge mclk);
        reg_rd = 1'h0;
        for (k = 0; k < 4 && reg_rvalid !== 1'h1; k++) @(negedge mclk);
        if (k == 4) begin
            errors++;
            final_report();
        end else begin
            d = reg_rdata;
        end
    endtask
    task automatic ev(input ppi_src_t e, output logic lvl);
        @(negedge mclk);
        irq_event = e;
        #1 lvl = pin;
        @(negedge mclk);
        irq_event = 8'h00;
    endtask
    task automatic t_reset();
        chk("mode", 16'h0000, pin_mode);
        chk("oe", 16'h0000, pin_oe);
        rd(5'h11, q);
        chk("ctrl", 16'h0000, q);
        rd(5'h12, q);
        chk("stat", 16'h0000, q);
        rd(5'h05, q);
        chk("unmapped", 16'h0000, q);
        $display("test reset done");
    endtask
    task automatic t_sleep();
        wr(5'h00, 16'h0800);
        chk("pd bit", 16'h0001, power_down);
        wr(5'h00, 16'h0000);
        chk("pd clr", 16'h0000, power_down);
        ext_low = 1'h1;
        repeat (3) @(negedge mclk);
        chk("pd pin", 16'h0001, power_down);
        rd(5'h00, q);
        chk("basic", 16'h0800, q);
        wr(5'h11, 16'h0001);
        @(negedge mclk);
        chk("pd exit", 16'h0000, power_down);
        chk("mode out", 16'h0001, pin_mode);
        ext_low = 1'h0;
        $display("test sleep done");
    endtask
    task automatic t_irq();
        wr(5'h11, 16'h0003);
        wr(5'h12, 16'h0060);
        ev(8'h20, p);
        chk("pin low", 16'h0000, p);
        chk("pin held", 16'h0000, pin);
        rd(5'h12, q);
        chk("flags", 16'h2060, q);
        chk("pin free", 16'h0001, pin);
        rd(5'h12, q);
        chk("cleared", 16'h0060, q);
        $display("test irq done");
    endtask
    task automatic t_mask();
        ev(8'h01, p);
        chk("masked", 16'h0001, p);
        rd(5'h12, q);
        chk("flag0", 16'h0160, q);
        wr(5'h11, 16'h0001);
        ev(8'h20, p);
        chk("no enable", 16'h0001, p);
        rd(5'h12, q);
        chk("flag5", 16'h2060, q);
        $display("test mask done");
    endtask
    initial begin
        repeat (4) @(negedge mclk);
        arst_n = 1'h1;
        t_reset();
        t_sleep();
        t_irq();
        t_mask();
        final_report();
    end
endmodule
